/* hdl/tx_beat_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module tx_beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic     push;
    logic     pop;

    assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = mem[st_ff.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_ff.wp] <= in_data;
        end
    end
endmodule // tx_beat_fifo
`default_nettype wire

/* hdl/tx_core_end.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1 - High end marker flags packet's final write.
// RULE2 - End marker accepted on either line half.
// RULE3 - End marker advances line within partition.
// RULE4 - Error marker records current packet errored.
// RULE5 - Error marker only alongside end marker.
// RULE6 - Strobe captures 64-bit word into RAM.
// RULE7 - Each write carries 8-bit logical port.
// RULE8 - Line terminate advances partition line pointer.
// RULE9 - 3-bit select picks one of eight partitions.
// RULE10 - Two writes per line unless packet ends.
// RULE11 - Start marker on first write of line; the user end sets it only on the first write of a packet.
// RULE12 - No valid bytes means no RAM write.
// RULE13 - Inputs sampled on user write clock; the core samples them on its own clk.
module tx_core_end #(
    parameter int LINE_AW    = tx_wr_pkg::LINE_AW,
    parameter int FIFO_DEPTH = tx_wr_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // Link.
    tx_wr_if.core                              link,
    // RAM read-back.
    input  wire logic [tx_wr_pkg::PART_W-1:0]  rd_part,
    input  wire logic [LINE_AW-1:0]            rd_line,
    input  wire logic                          rd_half,
    output logic [tx_wr_pkg::DATA_W-1:0]       rd_word,
    output logic [tx_wr_pkg::PORT_W-1:0]       rd_port,
    // Status.
    output logic [tx_wr_pkg::NUM_PART*LINE_AW-1:0] line_ptr,
    output logic [tx_wr_pkg::NUM_PART-1:0]     pkt_errored,
    output logic                               ram_write,
    output logic                               fifo_stall
);
    localparam int NP = tx_wr_pkg::NUM_PART;
    localparam int RW = 1 << (tx_wr_pkg::PART_W + LINE_AW + 1);

    typedef struct packed {
        logic [NP-1:0][LINE_AW-1:0] line;
        logic [NP-1:0]              half;
        logic [NP-1:0]              err;
        logic                       wr;
        logic                       stall;
        logic [tx_wr_pkg::DATA_W-1:0] rword;
        logic [tx_wr_pkg::PORT_W-1:0] rport;
    } core_st_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Input FIFO; inputs are taken on the core's clk, not link.tx_write_clock.
    tx_wr_pkg::tx_beat_t in_beat;
    tx_wr_pkg::tx_beat_t q_beat;
    logic                in_ready;
    logic                q_valid;
    logic                q_ready;

    always_comb begin
        in_beat      = '0;
        in_beat.word = link.tx_write_word;                         // [RULE6]
        in_beat.bv   = link.tx_byte_valid;
        in_beat.port = link.tx_logical_port_id;                    // [RULE7]
        in_beat.part = link.tx_partition_select;                   // [RULE9]
        in_beat.sop  = link.tx_packet_start_flag;
        in_beat.eop  = link.tx_packet_end_flag;                    // [RULE1]
        in_beat.err  = link.tx_packet_error_flag;
        in_beat.term = link.tx_line_terminate;
    end

    tx_beat_fifo #(
        .WIDTH (tx_wr_pkg::BEAT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),                                          // [RULE13]
        .reset_n   (reset_n),
        .in_valid  (link.tx_write_strobe),
        .in_ready  (in_ready),
        .in_data   (in_beat),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_beat)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Partitioned RAM and write pointers.
    logic [tx_wr_pkg::DATA_W-1:0] ram_d [RW];
    logic [tx_wr_pkg::PORT_W-1:0] ram_p [RW];
    core_st_t st_ff;
    core_st_t nxt_st;
    logic     do_wr;
    logic [tx_wr_pkg::PART_W+LINE_AW:0] wa;

    function automatic logic [tx_wr_pkg::PART_W+LINE_AW:0] addr_of(
        input logic [tx_wr_pkg::PART_W-1:0] p,
        input logic [LINE_AW-1:0]           l,
        input logic                         h
    );
        addr_of = {p, l, h};
    endfunction

    assign q_ready = 1'b1;
    assign do_wr   = q_valid && (q_beat.bv != '0);                 // [RULE12]
    assign wa      = addr_of(q_beat.part, st_ff.line[q_beat.part], st_ff.half[q_beat.part]);

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.wr    = do_wr;
        nxt_st.stall = !in_ready;
        nxt_st.rword = ram_d[addr_of(rd_part, rd_line, rd_half)];
        nxt_st.rport = ram_p[addr_of(rd_part, rd_line, rd_half)];
        if (q_valid) begin
            if (q_beat.sop) begin
                nxt_st.err[q_beat.part] = 1'b0;
            end
            if (q_beat.eop && q_beat.err) begin
                nxt_st.err[q_beat.part] = 1'b1;                    // [RULE4]
            end
            if (q_beat.eop || q_beat.term || (do_wr && st_ff.half[q_beat.part])) begin
                nxt_st.line[q_beat.part] = st_ff.line[q_beat.part] + 1'b1; // [RULE2] [RULE3] [RULE8]
                nxt_st.half[q_beat.part] = tx_wr_pkg::HALF_RST;
            end else if (do_wr) begin
                nxt_st.half[q_beat.part] = 1'b1;                   // [RULE10]
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            ram_d[wa] <= q_beat.word;                              // [RULE6]
            ram_p[wa] <= q_beat.port;                              // [RULE7]
        end
    end

    assign line_ptr    = st_ff.line;
    assign pkt_errored = st_ff.err;
    assign ram_write   = st_ff.wr;
    assign fifo_stall  = st_ff.stall;
    assign rd_word     = st_ff.rword;
    assign rd_port     = st_ff.rport;
endmodule // tx_core_end
`default_nettype wire

/* hdl/tx_user_end.sv */
`timescale 1ns/10ps
`default_nettype none
module tx_user_end (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // User request side.
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic [tx_wr_pkg::DATA_W-1:0]  req_word,
    input  wire logic [tx_wr_pkg::BV_W-1:0]    req_bv,
    input  wire logic [tx_wr_pkg::PORT_W-1:0]  req_port,
    input  wire logic [tx_wr_pkg::PART_W-1:0]  req_part,
    input  wire logic                          req_eop,
    input  wire logic                          req_err,
    input  wire logic                          req_term,
    // Link.
    tx_wr_if.user                              link
);
    typedef struct packed {
        tx_wr_pkg::tx_beat_t beat;
        logic                we;
        logic                second;
        logic                in_pkt;
    } usr_st_t;

    usr_st_t             st_ff;
    usr_st_t             nxt_st;
    logic                take;
    tx_wr_pkg::tx_beat_t fv;

    assign req_ready = 1'b1;
    assign take      = req_valid;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.we = 1'b0;
        fv        = '0;
        if (take) begin
            fv.word = req_word;
            fv.bv   = req_bv;
            fv.port = req_port;                                   // [RULE7]
            fv.part = req_part;                                   // [RULE9]
            fv.eop  = req_eop;                                    // [RULE1]
            fv.err  = req_eop && req_err;                         // [RULE5]
            fv.term = req_term;
            fv.sop  = !st_ff.in_pkt && !st_ff.second;             // [RULE11]
            nxt_st.we   = 1'b1;                                   // [RULE6]
            nxt_st.beat = fv;
            nxt_st.second = !(st_ff.second || req_eop || req_term); // [RULE10]
            nxt_st.in_pkt = !req_eop;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.tx_write_clock       = clk;                       // [RULE13]
    assign link.tx_write_strobe      = st_ff.we;
    assign link.tx_write_word        = st_ff.beat.word;
    assign link.tx_byte_valid        = st_ff.beat.bv;
    assign link.tx_logical_port_id   = st_ff.beat.port;
    assign link.tx_partition_select  = st_ff.beat.part;
    assign link.tx_packet_start_flag = st_ff.we && st_ff.beat.sop;
    assign link.tx_packet_end_flag   = st_ff.we && st_ff.beat.eop;
    assign link.tx_packet_error_flag = st_ff.we && st_ff.beat.err;
    assign link.tx_line_terminate    = st_ff.we && st_ff.beat.term;
endmodule // tx_user_end
`default_nettype wire

/* hdl/tx_wr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface tx_wr_if;
    logic                            tx_write_clock;
    logic                            tx_write_strobe;
    logic [tx_wr_pkg::DATA_W-1:0]    tx_write_word;
    logic [tx_wr_pkg::BV_W-1:0]      tx_byte_valid;
    logic [tx_wr_pkg::PORT_W-1:0]    tx_logical_port_id;
    logic [tx_wr_pkg::PART_W-1:0]    tx_partition_select;
    logic                            tx_packet_start_flag;
    logic                            tx_packet_end_flag;
    logic                            tx_packet_error_flag;
    logic                            tx_line_terminate;

    modport user (
        output tx_write_clock, tx_write_strobe, tx_write_word, tx_byte_valid,
        output tx_logical_port_id, tx_partition_select, tx_packet_start_flag,
        output tx_packet_end_flag, tx_packet_error_flag, tx_line_terminate
    );
    modport core (
        input tx_write_clock, tx_write_strobe, tx_write_word, tx_byte_valid,
        input tx_logical_port_id, tx_partition_select, tx_packet_start_flag,
        input tx_packet_end_flag, tx_packet_error_flag, tx_line_terminate
    );
endinterface : tx_wr_if
`default_nettype wire

/* hdl/tx_wr_pkg.sv */
package tx_wr_pkg;
    // Widths of the write port.
    localparam int DATA_W     = 64;
    localparam int BV_W       = 8;
    localparam int PORT_W     = 8;
    localparam int PART_W     = 3;
    localparam int NUM_PART   = 8;
    localparam int LINE_AW    = 4;
    localparam int FIFO_DEPTH = 16;
    // Values after reset.
    localparam logic [LINE_AW-1:0] LINE_RST = 4'h0;
    localparam logic               HALF_RST = 1'b0;

    // Payload carried through the FIFO and across the link.
    typedef struct packed {
        logic [DATA_W-1:0] word;
        logic [BV_W-1:0]   bv;
        logic [PORT_W-1:0] port;
        logic [PART_W-1:0] part;
        logic              sop;
        logic              eop;
        logic              err;
        logic              term;
    } tx_beat_t;

    localparam int BEAT_W = $bits(tx_beat_t);
endpackage : tx_wr_pkg

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk, reset_n = 1'b0, req_valid = 1'b0, req_eop = 1'b0, req_err = 1'b0;
    logic        req_term = 1'b0, rd_half = 1'b0, ram_write, fifo_stall;
    logic [63:0] req_word = 64'h0, rd_word;
    logic [7:0]  req_bv = 8'h0, req_port = 8'h0, rd_port, pkt_errored;
    logic [2:0]  req_part = 3'h0, rd_part = 3'h0;
    logic [3:0]  rd_line = 4'h0, exp_ptr [8] = '{default: 4'h0};
    logic [31:0] line_ptr;
    bit          half_q [8];
    int          num_errors = 0, num_checks = 0, n_wr = 0, exp_wr = 0;
    ////////////////////////////////////////////////////////////////
    tx_wr_if link_if ();
    tx_user_end tx_user_end_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(), .req_word(req_word), .req_bv(req_bv), .req_port(req_port),
        .req_part(req_part), .req_eop(req_eop), .req_err(req_err), .req_term(req_term),
        .link(link_if));
    tx_core_end #(.LINE_AW(4), .FIFO_DEPTH(16)) tx_core_end_i (.clk(clk), .reset_n(reset_n),
        .link(link_if), .rd_part(rd_part), .rd_line(rd_line), .rd_half(rd_half),
        .rd_word(rd_word), .rd_port(rd_port), .line_ptr(line_ptr),
        .pkt_errored(pkt_errored), .ram_write(ram_write), .fifo_stall(fifo_stall));
    tx_link_checker tx_link_checker_i (.tx_write_clock(link_if.tx_write_clock),
        .reset_n(reset_n), .tx_write_strobe(link_if.tx_write_strobe),
        .tx_logical_port_id(link_if.tx_logical_port_id),
        .tx_partition_select(link_if.tx_partition_select),
        .tx_packet_start_flag(link_if.tx_packet_start_flag),
        .tx_packet_end_flag(link_if.tx_packet_end_flag),
        .tx_packet_error_flag(link_if.tx_packet_error_flag),
        .tx_line_terminate(link_if.tx_line_terminate));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ram_write === 1'b1) n_wr++;
    end
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic send(input logic [2:0] p, input logic [63:0] w, input logic [7:0] bv,
                        input logic e, input logic r, input logic t);
        req_valid <= 1'b1;
        req_part <= p;
        req_port <= 8'h40 + {5'h0, p};
        req_word <= w;
        req_bv <= bv;
        req_eop <= e;
        req_err <= r;
        req_term <= t;
        if (bv != 8'h0) exp_wr++;
        if (e || t || half_q[p]) exp_ptr[p]++;
        half_q[p] = !(e || t || half_q[p]);
        @(posedge clk);
    endtask
    task automatic idle;
        req_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic chk_state;
        for (int p = 0; p < 8; p++) chk("line_ptr", 64'(exp_ptr[p]), 64'(line_ptr[p*4 +: 4]));
        chk("ram_write count", 64'(exp_wr), 64'(n_wr));
    endtask
    task automatic rd(input logic [2:0] p, input logic [3:0] l, input logic h, input logic [63:0] w);
        rd_part <= p;
        rd_line <= l;
        rd_half <= h;
        repeat (2) @(posedge clk);
        #1;
        chk("rd_word", w, rd_word);
        chk("rd_port", 64'(8'h40 + {5'h0, p}), 64'(rd_port));
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_line;
        send(3'h0, 64'h0123456789ABCDEF, 8'hFF, 1'b0, 1'b0, 1'b0);
        send(3'h0, 64'hFEDCBA9876543210, 8'hFF, 1'b1, 1'b0, 1'b0);
        idle();
        chk_state();
        rd(3'h0, 4'h0, 1'b0, 64'h0123456789ABCDEF);
        rd(3'h0, 4'h0, 1'b1, 64'hFEDCBA9876543210);
        $display("done t_line");
    endtask
    task automatic t_err;
        send(3'h1, 64'h1111, 8'hFF, 1'b1, 1'b1, 1'b0);
        idle();
        chk("pkt_errored", 64'h2, 64'(pkt_errored));
        send(3'h1, 64'h2222, 8'hFF, 1'b0, 1'b0, 1'b0);
        send(3'h1, 64'h3333, 8'hFF, 1'b1, 1'b0, 1'b0);
        idle();
        chk("pkt_errored", 64'h0, 64'(pkt_errored));
        chk_state();
        rd(3'h1, 4'h1, 1'b1, 64'h3333);
        $display("done t_err");
    endtask
    task automatic t_term;
        send(3'h2, 64'h4444, 8'hFF, 1'b0, 1'b1, 1'b0);
        send(3'h2, 64'h5555, 8'hFF, 1'b0, 1'b1, 1'b1);
        send(3'h3, 64'h6666, 8'h00, 1'b1, 1'b0, 1'b0);
        idle();
        chk("pkt_errored", 64'h0, 64'(pkt_errored));
        chk_state();
        $display("done t_term");
    endtask
    task automatic t_parts;
        for (int p = 0; p < 8; p++) send(3'(p), 64'(p), 8'h80, 1'b1, 1'b0, 1'b0);
        idle();
        chk_state();
        $display("done t_parts");
    endtask
    task automatic t_fifo;
        int stalls;
        stalls = 0;
        for (int i = 0; i < 20; i++) begin
            send(3'h4, 64'h100 + 64'(i), 8'hFF, 1'(i == 19), 1'b0, 1'b0);
            if (fifo_stall !== 1'b0) stalls++;
        end
        idle();
        if (fifo_stall !== 1'b0) stalls++;
        chk("fifo_stall count", 64'h0, 64'(stalls));
        chk_state();
        rd(3'h4, 4'hA, 1'b0, 64'h112);
        rd(3'h4, 4'hA, 1'b1, 64'h113);
        $display("done t_fifo");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_line();
        t_err();
        t_term();
        t_parts();
        t_fifo();
        results();
    end
endmodule // testbench
`default_nettype wire

/* test/tx_link_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module tx_link_checker (
    // Link clock and reset.
    input wire logic       tx_write_clock,
    input wire logic       reset_n,
    // Link signals.
    input wire logic       tx_write_strobe,
    input wire logic [7:0] tx_logical_port_id,
    input wire logic [2:0] tx_partition_select,
    input wire logic       tx_packet_start_flag,
    input wire logic       tx_packet_end_flag,
    input wire logic       tx_packet_error_flag,
    input wire logic       tx_line_terminate
);
    ////////////////////////////////////////////////////////////////
    // Tracks the open half line.
    logic       half_ff;
    logic [2:0] part_ff;
    logic [7:0] port_ff;
    always_ff @(posedge tx_write_clock or negedge reset_n) begin
        if (!reset_n) begin
            half_ff <= 1'b0;
            part_ff <= 3'h0;
            port_ff <= 8'h0;
        end else if (tx_write_strobe) begin
            half_ff <= !half_ff && !tx_packet_end_flag && !tx_line_terminate;
            part_ff <= tx_partition_select;
            port_ff <= tx_logical_port_id;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge tx_write_clock); endclocking
    default disable iff (!reset_n);
    sequence end_beat;
        tx_write_strobe && tx_packet_end_flag;
    endsequence
    sequence open_start;
        tx_packet_start_flag && !tx_packet_end_flag;
    endsequence
    end_has_strobe_a: assert property (tx_packet_end_flag |-> tx_write_strobe)
        else $error("end flag without strobe");
    err_with_end_a: assert property (tx_packet_error_flag |-> tx_packet_end_flag)
        else $error("error flag without end flag");
    start_first_half_a: assert property (tx_packet_start_flag |-> tx_write_strobe && !half_ff)
        else $error("start flag not on first half");
    next_start_a: assert property (end_beat ##1 tx_write_strobe |-> tx_packet_start_flag)
        else $error("write after end lacks start");
    single_start_a: assert property (open_start ##1 tx_write_strobe |-> !tx_packet_start_flag)
        else $error("start flag repeated in packet");
    term_has_strobe_a: assert property (tx_line_terminate |-> tx_write_strobe)
        else $error("terminate without strobe");
    line_same_part_a: assert property (tx_write_strobe && half_ff |-> tx_partition_select == part_ff)
        else $error("partition changed inside line");
    line_same_port_a: assert property (tx_write_strobe && half_ff |-> tx_logical_port_id == port_ff)
        else $error("port changed inside line");
endmodule // tx_link_checker
`default_nettype wire
